//--- pid_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "pid_consts.vh"
module pid_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Stream and decode
	input wire logic        ib_valid,
	input wire logic [7:0]  ib_data,
	input wire logic        dec_valid,
	input wire logic [3:0]  dec_func,
	input wire logic [31:0] dec_oper,
	input wire logic        dec_fp,
	input wire logic        dec_fp_sel_vld,
	input wire logic        dec_push_id,
	input wire logic        trap_valid,
	input wire logic [3:0]  trap_code,
	// Execution
	input wire logic        ex_done,
	input wire logic        ex_ovf,
	input wire logic        ex_fp_denorm,
	input wire logic        xtrap_valid,
	input wire logic [3:0]  xtrap_code,
	input wire logic [1:0]  ex_extra_cyc
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_prefix_silent: assert property (
		ib_valid && ib_data[7:4] == 4'h2 |=> !dec_valid && !trap_valid)
		else $error("prefix byte dispatched");
	// Guarded by a dispatch so the chain is known empty
	a_short_oper: assert property (
		dec_valid && ib_valid && ib_data[7:4] == 4'h4
		|=> !dec_valid || dec_oper == {28'h0, $past(ib_data[3:0])})
		else $error("short operand wrong");
	a_pfix_chain: assert property (
		dec_valid && ib_valid && ib_data == 8'h23
		##1 ib_valid && ib_data == 8'h45 |=> dec_valid && dec_oper == 32'h35)
		else $error("prefix chain wrong");
	a_late_nfix: assert property (
		ib_valid && ib_data[7:4] == 4'h2 ##1 ib_valid && ib_data[7:4] == 4'h6
		|=> trap_valid && trap_code == `PID_E_ILLEGAL)
		else $error("late negative prefix passed");
	a_dev_id: assert property (
		dec_push_id |-> dec_valid && dec_func == `PID_FN_OPR
		&& dec_oper == `PID_DEVID) else $error("identity wrong");
	a_sel_entry: assert property (
		dec_fp_sel_vld |-> dec_valid && dec_fp && dec_oper == `PID_OP_FPENTRY)
		else $error("selector without entry");
	a_ovf_code: assert property (
		xtrap_valid && xtrap_code == `PID_E_OVF |-> $past(ex_done && ex_ovf))
		else $error("overflow trap uncaused");
	a_denorm_cyc: assert property (
		ex_extra_cyc != 2'h0
		|-> ex_extra_cyc == `PID_DENORM_CYC && $past(ex_done && ex_fp_denorm))
		else $error("extra cycles wrong");
	c_dev_id: cover property (dec_push_id);
	c_sel: cover property (dec_fp_sel_vld);
	c_ovf: cover property (xtrap_valid && xtrap_code == `PID_E_OVF);
endmodule // pid_chk
bind pid_decoder pid_chk u_chk (.clk, .sys_rst, .ib_valid, .dec_valid,
	.dec_fp, .dec_fp_sel_vld, .dec_push_id, .trap_valid, .ib_data,
	.dec_oper, .dec_func, .trap_code, .ex_done, .ex_ovf, .ex_fp_denorm,
	.xtrap_valid, .xtrap_code, .ex_extra_cyc);
`default_nettype wire

//--- pid_consts.vh
// Summary of operation
// - Operand below 16 fits one byte
// - One positive prefix per extra operand nibble
// - Negative operand starts with negative prefix
// - Sixteen direct function codes decoded
// - Small operation codes in one operate byte
// - Larger operation codes use positive prefix
// - Negative prefix opens negative operation space
// - Load constant selects floating entry operation
// - Floating ops also have direct encodings
// - Undefined encodings trap as illegal
// - Identity operation pushes device identity
// - Checked arithmetic traps overflow, divide zero
// - Misaligned word/half-word access raises error
// - Protected process bad address raises error
// - Barred instructions rejected per process class
// - Breakpoints only in supervisory class
// - Flag descheduling, interruptible, timesliceable
// - Denormal floating ops take two extra cycles
// - Report floating exception conditions by class
`ifndef PID_CONSTS_VH
`define PID_CONSTS_VH
`define PID_REG_CTRL     12'h000
`define PID_REG_STATUS   12'h004
`define PID_REG_DEVID    12'h008
`define PID_REG_LAST     12'h00C
`define PID_CTRL_RST     4'h1
`define PID_FN_JUMP      4'h0
`define PID_FN_PFIX      4'h2
`define PID_FN_LDC       4'h4
`define PID_FN_NFIX      4'h6
`define PID_FN_OPR       4'hF
`define PID_NIB_LIMIT    32'h0000000F
`define PID_OP_NEG       32'hFFFFFFE6
`define PID_OP_FPENTRY   32'h0000008F
`define PID_OP_LDDEVID   32'h0000007C
`define PID_FP_LO        32'h00000090
`define PID_FP_HI        32'h000000BF
`define PID_SEL_MAX      32'h0000001F
// Identity value is arbitrary, not an allocated number
`define PID_DEVID        32'h000000A5
`define PID_DENORM_CYC   2'h2
`define PID_CLS_G        2'h0
`define PID_CLS_L        2'h1
`define PID_CLS_P        2'h2
`define PID_E_NONE       4'h0
`define PID_E_ILLEGAL    4'h1
`define PID_E_OVF        4'h2
`define PID_E_DIVZ       4'h3
`define PID_E_ALIGN      4'h4
`define PID_E_ADDR       4'h5
`define PID_E_CLASS      4'h6
`define PID_E_FP_INV     4'h7
`define PID_E_FP_DZ      4'h8
`define PID_E_FP_OVF     4'h9
`define PID_E_FP_UNF     4'hA
`define PID_E_FP_INX     4'hB
`define PID_F_LEGAL      0
`define PID_F_O          1
`define PID_F_U          2
`define PID_F_M          3
`define PID_F_P          4
`define PID_F_G          5
`define PID_F_L          6
`define PID_F_B          7
`define PID_F_T          8
`define PID_F_D          9
`define PID_F_I          10
`define PID_F_DN         11
`define PID_F_FP         12
`endif

//--- pid_decoder.v
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pid_consts.vh"
module pid_decoder (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Byte stream from fetch
	input  wire        ib_valid,
	input  wire [7:0]  ib_data,
	// Decoded instruction to pipeline
	output reg         dec_valid,
	output reg  [3:0]  dec_func,
	output reg  [31:0] dec_oper,
	output reg         dec_fp,
	output reg  [4:0]  dec_fp_sel,
	output reg         dec_fp_sel_vld,
	output reg         dec_push_id,
	output reg         dec_desched,
	output reg         dec_intr,
	output reg         dec_tslice,
	output reg         dec_brk,
	// Decode traps
	output reg         trap_valid,
	output reg  [3:0]  trap_code,
	// Execution results of last dispatched instruction
	input  wire        ex_done,
	input  wire        ex_ovf,
	input  wire        ex_divz,
	input  wire        ex_half,
	input  wire [1:0]  ex_addr_lo,
	input  wire        ex_addr_bad,
	input  wire [4:0]  ex_fp_flags,
	input  wire        ex_fp_denorm,
	// Execution traps and timing
	output reg         xtrap_valid,
	output reg  [3:0]  xtrap_code,
	output reg  [1:0]  ex_extra_cyc
);

	reg [31:0] oreg_q, oreg_d;
	reg        chain_q, chain_d;
	reg [31:0] areg_q;
	reg [3:0]  ctrl_q;
	reg        seen_q;
	reg [3:0]  last_err_q;
	reg [12:0] last_feat_q;
	reg [7:0]  trap_cnt_q;

	wire       en     = ctrl_q[0];
	wire [1:0] cls    = ctrl_q[2:1];
	wire       brk_en = ctrl_q[3];

	// Direct function features
	function [12:0] fn_feat;
		input [3:0] fn;
		begin
			fn_feat = 13'h0001;
			case (fn)
			// Jump: breakpoint, timeslice, deschedule
			4'h0:
				fn_feat = 13'h0381;
			// Non-local access: alignment and address
			4'h3, 4'hE:
				fn_feat = 13'h000D;
			// Workspace access: address only
			4'h7, 4'h9, 4'hB, 4'hD:
				fn_feat = 13'h0009;
			// Add constant: overflow
			4'h8:
				fn_feat = 13'h0003;
			default:
				fn_feat = 13'h0001;
			endcase
		end
	endfunction

	// Operation features; zero means undefined
	function [12:0] op_feat;
		input [31:0] op;
		begin
			op_feat = 13'h0000;
			if (op >= `PID_FP_LO && op <= `PID_FP_HI)
				op_feat = 13'h1801;
			else if (op == `PID_OP_NEG || op == `PID_OP_LDDEVID ||
			    op == `PID_OP_FPENTRY)
				op_feat = 13'h0001;
			else if (op[31:8] == 24'h000000) begin
				case (op[7:0])
				// Checked arithmetic: overflow or divide by zero
				8'h05, 8'h0C, 8'h53, 8'h72,
				8'h2C, 8'h1F, 8'h16, 8'h38,
				8'h1A:
					op_feat = 13'h0003;
				// Byte access, address checked for protected class
				8'h01, 8'h3B:
					op_feat = 13'h0009;
				// Block moves, interruptible
				8'h5C, 8'h5D, 8'h5E, 8'h4A:
					op_feat = 13'h0409;
				// Channel and timer waits; all but 8'h2E deschedule
				8'h07, 8'h0B, 8'h0F, 8'h0E,
				8'h2B, 8'h51:
					op_feat = 13'h0611;
				8'h44:
					op_feat = 13'h0211;
				8'h2E:
					op_feat = 13'h0411;
				// Alternative and timer setup, barred when protected
				8'h4E, 8'h47, 8'h43, 8'h45:
					op_feat = 13'h0011;
				// Plain operations, no trap or scheduling feature
				8'h46, 8'h4B, 8'h33, 8'h32,
				8'h41, 8'h40, 8'h09, 8'h04,
				8'h52, 8'h08, 8'h37, 8'h4F,
				8'h31, 8'h36, 8'h35, 8'h19,
				8'h00, 8'h3A, 8'h56, 8'h1D,
				8'h4C, 8'h42, 8'h5A, 8'h79,
				8'h5B, 8'h74, 8'h75, 8'h76,
				8'h77, 8'h78, 8'h02, 8'h0A,
				8'h81, 8'h34, 8'h3F, 8'h22:
					op_feat = 13'h0001;
				default:
					op_feat = 13'h0000;
				endcase
			end
		end
	endfunction

	// Class barring check
	function barred;
		input [12:0] f;
		input [1:0]  c;
		begin
			barred = (f[`PID_F_P] && c == `PID_CLS_P) ||
				(f[`PID_F_G] && c == `PID_CLS_G) ||
				(f[`PID_F_L] && c == `PID_CLS_L);
		end
	endfunction

	wire [3:0]  fn       = ib_data[7:4];
	wire [31:0] full_op  = oreg_q | {28'h0000000, ib_data[3:0]};
	wire        take     = ib_valid && en;
	wire        is_pfx   = fn == `PID_FN_PFIX || fn == `PID_FN_NFIX;
	wire        is_opr   = fn == `PID_FN_OPR;
	wire        is_fpent = is_opr && full_op == `PID_OP_FPENTRY;
	wire        sel_ok   = areg_q <= `PID_SEL_MAX;
	wire        bad_nfix = fn == `PID_FN_NFIX && chain_q;

	reg [12:0] feat;
	always @* begin
		if (is_opr)
			feat = op_feat(full_op);
		else
			feat = fn_feat(fn);
		if (is_fpent && sel_ok)
			feat = 13'h1801;
		else if (is_fpent)
			feat = 13'h0000;
	end

	wire illegal = !feat[`PID_F_LEGAL] || bad_nfix;
	wire cls_bad = barred(feat, cls);

	// Operand register
	// Disabled bytes leave the chain untouched, so a stream
	// paused mid-prefix resumes where it stopped
	always @* begin
		oreg_d  = oreg_q;
		chain_d = chain_q;
		if (take) begin
			if (fn == `PID_FN_PFIX) begin
				oreg_d  = full_op << 4;
				chain_d = 1'b1;
			end else if (fn == `PID_FN_NFIX && chain_q) begin
				// Late negative prefix traps; drop the chain so the
				// next instruction starts from a clean operand
				oreg_d  = 32'h00000000;
				chain_d = 1'b0;
			end else if (fn == `PID_FN_NFIX) begin
				oreg_d  = (~full_op) << 4;
				chain_d = 1'b1;
			end else begin
				oreg_d  = 32'h00000000;
				chain_d = 1'b0;
			end
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			oreg_q  <= 32'h00000000;
			chain_q <= 1'b0;
		end else begin
			oreg_q  <= oreg_d;
			chain_q <= chain_d;
		end
	end

	// Dispatch stage
	always @(posedge clk) begin
		if (sys_rst) begin
			dec_valid      <= 1'b0;
			dec_func       <= 4'h0;
			dec_oper       <= 32'h00000000;
			dec_fp         <= 1'b0;
			dec_fp_sel     <= 5'h00;
			dec_fp_sel_vld <= 1'b0;
			dec_push_id    <= 1'b0;
			dec_desched    <= 1'b0;
			dec_intr       <= 1'b0;
			dec_tslice     <= 1'b0;
			dec_brk        <= 1'b0;
			trap_valid     <= 1'b0;
			trap_code      <= `PID_E_NONE;
			areg_q         <= 32'h00000000;
			last_feat_q    <= 13'h0000;
		end else begin
			dec_valid      <= 1'b0;
			trap_valid     <= 1'b0;
			dec_fp_sel_vld <= 1'b0;
			dec_push_id    <= 1'b0;
			dec_brk        <= 1'b0;
			// A trap replaces the pulse; level flags keep the last legal one
			// Only a dispatching byte or a late negative prefix gets here; other prefixes are absorbed
			if (take && !is_pfx || take && bad_nfix) begin
				dec_func <= fn;
				dec_oper <= full_op;
				if (illegal || cls_bad) begin
					trap_valid <= 1'b1;
					trap_code  <= illegal ? `PID_E_ILLEGAL :
						`PID_E_CLASS;
				end else begin
					dec_valid   <= 1'b1;
					dec_fp      <= feat[`PID_F_FP];
					dec_desched <= feat[`PID_F_D];
					dec_intr    <= feat[`PID_F_I];
					dec_tslice  <= feat[`PID_F_T];
					dec_brk     <= feat[`PID_F_B] && brk_en &&
						cls == `PID_CLS_G;
					last_feat_q <= feat;
					if (is_fpent) begin
						dec_fp_sel     <= areg_q[4:0];
						dec_fp_sel_vld <= 1'b1;
					end
					if (fn == `PID_FN_LDC)
						areg_q <= full_op;
					if (is_opr && full_op == `PID_OP_LDDEVID) begin
						areg_q      <= `PID_DEVID;
						dec_oper    <= `PID_DEVID;
						dec_push_id <= 1'b1;
					end
				end
			end
		end
	end

	// Execution result checks
	wire        f_o  = last_feat_q[`PID_F_O];
	wire        f_u  = last_feat_q[`PID_F_U];
	wire        f_m  = last_feat_q[`PID_F_M];
	wire        f_fp = last_feat_q[`PID_F_FP];
	wire        misal = ex_half ? ex_addr_lo[0] : (ex_addr_lo != 2'b00);
	// One code per result; lower-priority conditions are dropped
	reg  [3:0]  xcode;
	always @* begin
		xcode = `PID_E_NONE;
		if (f_o && ex_ovf)
			xcode = `PID_E_OVF;
		else if (f_o && ex_divz)
			xcode = `PID_E_DIVZ;
		else if (f_u && misal)
			xcode = `PID_E_ALIGN;
		else if (f_m && cls == `PID_CLS_P && ex_addr_bad)
			xcode = `PID_E_ADDR;
		else if (f_fp && ex_fp_flags[0])
			xcode = `PID_E_FP_INV;
		else if (f_fp && ex_fp_flags[1])
			xcode = `PID_E_FP_DZ;
		else if (f_fp && ex_fp_flags[2])
			xcode = `PID_E_FP_OVF;
		else if (f_fp && ex_fp_flags[3])
			xcode = `PID_E_FP_UNF;
		else if (f_fp && ex_fp_flags[4])
			xcode = `PID_E_FP_INX;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			xtrap_valid  <= 1'b0;
			xtrap_code   <= `PID_E_NONE;
			ex_extra_cyc <= 2'h0;
		end else begin
			xtrap_valid  <= ex_done && xcode != `PID_E_NONE;
			ex_extra_cyc <= 2'h0;
			if (ex_done) begin
				xtrap_code <= xcode;
				if (last_feat_q[`PID_F_DN] && ex_fp_denorm)
					ex_extra_cyc <= `PID_DENORM_CYC;
			end
		end
	end

	// Sticky trap status; hardware set beats software clear
	wire any_trap = trap_valid || xtrap_valid;
	wire wr_acc   = psel && penable && pready && pwrite;
	wire clr_seen = wr_acc && paddr == `PID_REG_STATUS && pwdata[0];
	always @(posedge clk) begin
		if (sys_rst) begin
			seen_q     <= 1'b0;
			last_err_q <= `PID_E_NONE;
			trap_cnt_q <= 8'h00;
		end else begin
			if (any_trap) begin
				seen_q     <= 1'b1;
				last_err_q <= xtrap_valid ? xtrap_code : trap_code;
				trap_cnt_q <= trap_cnt_q + 8'h01;
			end else if (clr_seen) begin
				seen_q <= 1'b0;
			end
		end
	end

	// APB: one wait-free access phase, answer registered in setup
	function mapped;
		input [11:0] a;
		begin
			mapped = a == `PID_REG_CTRL || a == `PID_REG_STATUS ||
				a == `PID_REG_DEVID || a == `PID_REG_LAST;
		end
	endfunction

	// Read data is latched at setup, so a register changing during
	// the access still returns the value it had at setup
	always @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q  <= `PID_CTRL_RST;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped(paddr);
			if (psel && !penable) begin
				case (paddr)
				`PID_REG_CTRL:
					prdata <= {28'h0000000, ctrl_q};
				`PID_REG_STATUS:
					prdata <= {16'h0000, trap_cnt_q, 3'h0,
						last_err_q, seen_q};
				`PID_REG_DEVID:
					prdata <= `PID_DEVID;
				`PID_REG_LAST:
					prdata <= {19'h00000, last_feat_q};
				default:
					prdata <= 32'h00000000;
				endcase
			end
			if (wr_acc && paddr == `PID_REG_CTRL)
				ctrl_q <= pwdata[3:0];
		end
	end

endmodule // pid_decoder
`default_nettype wire

//--- pid_far.sv
`timescale 1ns/10ps
`default_nettype none
module pid_far (
	// Clock
	input wire logic    clk,
	// Fetch bytes and execution results
	output logic        ib_valid,
	output logic [7:0]  ib_data,
	output logic        ex_done,
	output logic [11:0] ex_res
);
	initial {ib_valid, ex_done, ib_data, ex_res} = '0;
	task automatic put(input logic [7:0] b);
		@(posedge clk);
		ib_valid <= 1'b1;
		ib_data <= b;
	endtask
	// Stale lines toggle so nothing leans on a held value
	task automatic idle();
		@(posedge clk);
		ib_valid <= 1'b0;
		ex_done <= 1'b0;
		ib_data <= ~ib_data;
		ex_res <= ~ex_res;
	endtask
	task automatic done(input logic [11:0] v);
		@(posedge clk);
		ex_done <= 1'b1;
		ex_res <= v;
	endtask
endmodule // pid_far
`default_nettype wire

//--- prefixed_instruction_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pid_consts.vh"
module prefixed_instruction_decoder_tb;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
	logic ib_valid, ex_done, dec_valid, dec_fp, dec_fp_sel_vld, dec_push_id;
	logic dec_desched, dec_intr, dec_tslice, dec_brk, trap_valid, xtrap_valid;
	logic [31:0] pwdata, prdata, dec_oper, r;
	logic [11:0] paddr, ex_res;
	logic [7:0]  ib_data;
	logic [4:0]  dec_fp_sel;
	logic [3:0]  dec_func, trap_code, xtrap_code;
	logic [1:0]  ex_extra_cyc;
	int          fails, comparisons;
	pid_decoder uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .ib_valid, .ib_data,
		.dec_valid, .dec_func, .dec_oper, .dec_fp, .dec_fp_sel,
		.dec_fp_sel_vld, .dec_push_id, .dec_desched, .dec_intr,
		.dec_tslice, .dec_brk, .trap_valid, .trap_code, .ex_done,
		.ex_ovf(ex_res[11]), .ex_divz(ex_res[10]), .ex_half(ex_res[9]),
		.ex_addr_lo(ex_res[8:7]), .ex_addr_bad(ex_res[6]),
		.ex_fp_flags(ex_res[5:1]), .ex_fp_denorm(ex_res[0]),
		.xtrap_valid, .xtrap_code, .ex_extra_cyc);
	pid_far far (.clk, .ib_valid, .ib_data, .ex_done, .ex_res);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string n, input logic [39:0] s, x);
		comparisons++;
		if (s !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
		if (pready !== 1'b1) begin
			fails++;
			summarize();
		end else begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic feed(input logic [31:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) far.put(w[8 * i +: 8]);
		far.idle();
		#1;
	endtask
	task automatic dchk(input logic [31:0] w, input int n,
		input logic [35:0] x);
		feed(w, n);
		chk("decode", {trap_valid, dec_valid, dec_func, dec_oper}, {2'b01, x});
	endtask
	task automatic tchk(input logic [31:0] w, input int n,
		input logic [3:0] c);
		feed(w, n);
		chk("trap", {dec_valid, trap_valid, trap_code}, {2'b01, c});
	endtask
	task automatic xchk(input logic [11:0] v, input logic [6:0] x);
		far.done(v);
		far.idle();
		#1;
		chk("exec", {xtrap_valid, xtrap_code, ex_extra_cyc}, x);
	endtask
	initial begin
		{sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b1, 12'h008, 32'h0);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			chk("reg", {e, r}, i == 4 ? 33'h100000000 :
				i == 0 ? 33'h1 : i == 2 ? 33'hA5 : 33'h0);
		end
		dchk(32'h4143, 2, 36'h400000003);
		dchk(32'h432345, 3, 36'h400000035);
		dchk(32'h43412345, 4, 36'h400000035);
		dchk(32'h292847, 3, 36'h400000987);
		dchk(32'h6141, 2, 36'h4FFFFFFE1);
		dchk(32'h6F2F41, 3, 36'h4FFFFF0F1);
		for (int f = 0; f < 15; f++)
			if (f != 2 && f != 6)
				dchk({24'h0, f[3:0], 4'h3}, 1, {f[3:0], 32'h3});
		dchk(32'hF5, 1, 36'hF00000005);
		dchk(32'h21F6, 2, 36'hF00000016);
		dchk(32'h61F6, 2, 36'hFFFFFFFE6);
		dchk(32'h27FC, 2, {4'hF, `PID_DEVID});
		chk("id", dec_push_id, 1'b1);
		dchk(32'h4528FF, 3, 36'hF0000008F);
		chk("sel", {dec_fp, dec_fp_sel_vld, dec_fp_sel}, 7'h65);
		dchk(32'h29F0, 2, 36'hF00000090);
		chk("fp", {dec_fp, dec_fp_sel_vld}, 2'h2);
		xchk(12'h001, 7'h02);
		for (int b = 0; b < 5; b++) begin
			dchk(32'h29F0, 2, 36'hF00000090);
			xchk(12'h002 << b, {1'b1, 4'(7 + b), 2'h0});
		end
		tchk(32'h2161, 2, `PID_E_ILLEGAL);
		tchk(32'h61F5, 2, `PID_E_ILLEGAL);
		tchk(32'h224F28FF, 4, `PID_E_ILLEGAL);
		dchk(32'hF5, 1, 36'hF00000005);
		xchk(12'h800, 7'h48);
		dchk(32'hF5, 1, 36'hF00000005);
		xchk(12'h400, 7'h4C);
		dchk(32'h30, 1, 36'h300000000);
		xchk(12'h080, 7'h50);
		apb(1'b1, 12'h000, 32'h5);
		tchk(32'hF7, 1, `PID_E_CLASS);
		dchk(32'h73, 1, 36'h700000003);
		xchk(12'h040, 7'h54);
		apb(1'b1, 12'h000, 32'h9);
		dchk(32'h00, 1, 36'h0);
		chk("flags", {dec_brk, dec_desched, dec_tslice}, 3'h7);
		apb(1'b1, 12'h000, 32'hB);
		dchk(32'h00, 1, 36'h0);
		chk("brk", dec_brk, 1'b0);
		dchk(32'h24FA, 2, 36'hF0000004A);
		chk("intr", {dec_intr, dec_desched}, 2'h2);
		apb(1'b0, 12'h004, 32'h0);
		chk("status", {e, r}, 33'h000000D0B);
		apb(1'b1, 12'h004, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk("clear", {e, r}, 33'h000000D0A);
		summarize();
	end
endmodule // prefixed_instruction_decoder_tb
`default_nettype wire
